// ==== core/mahpm_pkg.sv ====
// Package: register map, field layout, reset values and carriers for the MAC address block
package mahpm_pkg;
  // Register byte offsets
  localparam logic [11:0] STATION_ADDR_UPPER_OFS = 12'h104;
  localparam logic [11:0] STATION_ADDR_LOWER_OFS = 12'h108;
  localparam logic [11:0] GROUP_HASH_UPPER_OFS = 12'h10C;
  localparam logic [11:0] GROUP_HASH_LOWER_OFS = 12'h110;
  localparam logic [11:0] PHY_MGMT_CONTROL_OFS = 12'h114;
  localparam logic [11:0] PHY_MGMT_VALUE_OFS = 12'h118;
  localparam logic [11:0] FILTER_CONTROL_OFS = 12'h128;
  // Reset values
  localparam logic [15:0] STATION_ADDR_UPPER_RST = 16'hFFFF;
  localparam logic [31:0] STATION_ADDR_LOWER_RST = 32'hFFFFFFFF;
  localparam logic [31:0] GROUP_HASH_RST = 32'h00000000;
  localparam logic [15:0] PHY_VALUE_RST = 16'h0000;
  localparam logic [4:0] PHY_FIELD_RST = 5'h00;
  // Control register field positions
  localparam int PHY_ADDR_MSB = 15;
  localparam int PHY_ADDR_LSB = 11;
  localparam int PHY_INDEX_MSB = 10;
  localparam int PHY_INDEX_LSB = 6;
  localparam int PHY_WRITE_BIT = 1;
  localparam int PHY_PENDING_BIT = 0;
  localparam int ACCEPT_ALL_GROUP_BIT = 0;

  // Request towards the PHY management port
  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] phy_addr;
    logic [4:0] index;
    logic [15:0] wdata;
  } mahpm_phy_req_t;

  // Answer from the PHY management port
  typedef struct packed {
    logic done;
    logic [15:0] rdata;
  } mahpm_phy_rsp_t;

  // One received destination address offered for filtering
  typedef struct packed {
    logic valid;
    logic [47:0] dest;
  } mahpm_rx_addr_t;

  // Filter verdict
  typedef struct packed {
    logic valid;
    logic station_match;
    logic group;
    logic accept;
  } mahpm_verdict_t;
endpackage : mahpm_pkg

// ==== core/mahpm_regs.sv ====
// MAC station address, group hash filter and indirect PHY management registers
// Behaviour
// - Upper address bits 15:0, reset all ones
// - Lower address full word, reset all ones
// - Octets one to six from low bytes
// - Address kept under reset-protection, not plain reset
// - Two 32-bit hash words, reset zero
// - Hash index from destination address
// - Index MSB picks word, rest picks bit
// - Accept multicast when selected bit set
// - Accept-all-group passes every multicast frame
// - Bits 10:6 select PHY register
// - Bit 1 selects write, else read
// - Software sets bit 0; device clears it
// - Busy reads one throughout access
// - Read data loaded on the same edge that busy clears
// - 16-bit data field, reset zero
`timescale 1ns/1ps
module mahpm_regs
  import mahpm_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Reset-protection reset for the station address
  input wire logic prot_resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive filter
  input wire mahpm_rx_addr_t rx_addr,
  output mahpm_verdict_t verdict,
  // PHY management port
  output mahpm_phy_req_t phy_req,
  input wire mahpm_phy_rsp_t phy_rsp
);

  // Register state
  logic [15:0] station_addr_upper;
  logic [31:0] station_addr_lower;
  logic [31:0] group_hash_upper;
  logic [31:0] group_hash_lower;
  logic [4:0] phy_addr;
  logic [4:0] phy_reg_index;
  logic phy_write_select;
  logic phy_access_pending;
  logic [15:0] phy_value;
  logic accept_all_group;

  // Controller states
  typedef enum logic [2:0] {
    MAHPM_IDLE = 3'b001,
    MAHPM_ISSUE = 3'b010,
    MAHPM_WAIT = 3'b100
  } mahpm_state_t;
  mahpm_state_t state;

  // Hash index: top six bits of the destination CRC
  function automatic logic [5:0] mahpm_hash(input logic [47:0] dest);
    logic [31:0] crc;
    crc = 32'hFFFFFFFF;
    for (int i = 0; i < 48; i++) begin
      crc = (crc[31] ^ dest[i]) ? ((crc << 1) ^ 32'h04C11DB7) : (crc << 1);
    end
    return crc[31:26];
  endfunction : mahpm_hash

  // Byte-lane merge of a write
  function automatic logic [31:0] mahpm_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction : mahpm_merge

  // APB decode
  logic access;
  logic wr;
  logic mapped;
  logic [31:0] next_word;
  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign mapped = paddr inside {STATION_ADDR_UPPER_OFS, STATION_ADDR_LOWER_OFS,
                                GROUP_HASH_UPPER_OFS, GROUP_HASH_LOWER_OFS,
                                PHY_MGMT_CONTROL_OFS, PHY_MGMT_VALUE_OFS,
                                FILTER_CONTROL_OFS};

  // Read data mux, reserved bits zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (paddr)
      STATION_ADDR_UPPER_OFS: rd_mux = {16'h0000, station_addr_upper};
      STATION_ADDR_LOWER_OFS: rd_mux = station_addr_lower;
      GROUP_HASH_UPPER_OFS: rd_mux = group_hash_upper;
      GROUP_HASH_LOWER_OFS: rd_mux = group_hash_lower;
      PHY_MGMT_CONTROL_OFS: rd_mux = {16'h0000, phy_addr, phy_reg_index, 4'h0,
                                      phy_write_select, phy_access_pending};
      PHY_MGMT_VALUE_OFS: rd_mux = {16'h0000, phy_value};
      FILTER_CONTROL_OFS: rd_mux = {31'h00000000, accept_all_group};
      default: rd_mux = 32'h00000000;
    endcase
  end
  assign next_word = mahpm_merge(rd_mux, pwdata, pstrb);

  // APB handshake: no wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
        pslverr <= !mapped;
      end else if (access) begin
        pslverr <= 1'b0;
      end
    end
  end

  // Station address, reset only by the protection reset
  always_ff @(posedge pclk or negedge prot_resetn) begin
    if (!prot_resetn) begin
      station_addr_upper <= STATION_ADDR_UPPER_RST;
      station_addr_lower <= STATION_ADDR_LOWER_RST;
    end else if (wr) begin
      if (paddr == STATION_ADDR_UPPER_OFS) begin
        station_addr_upper <= next_word[15:0];
      end
      if (paddr == STATION_ADDR_LOWER_OFS) begin
        station_addr_lower <= next_word;
      end
    end
  end

  // Group hash table and filter control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_hash_upper <= GROUP_HASH_RST;
      group_hash_lower <= GROUP_HASH_RST;
      accept_all_group <= 1'b0;
    end else if (wr) begin
      if (paddr == GROUP_HASH_UPPER_OFS) begin
        group_hash_upper <= next_word;
      end
      if (paddr == GROUP_HASH_LOWER_OFS) begin
        group_hash_lower <= next_word;
      end
      if (paddr == FILTER_CONTROL_OFS) begin
        accept_all_group <= next_word[ACCEPT_ALL_GROUP_BIT];
      end
    end
  end

  // Filter evaluation
  logic [5:0] hash_idx;
  logic hash_bit;
  logic [47:0] station;
  assign hash_idx = mahpm_hash(rx_addr.dest);
  assign hash_bit = hash_idx[5] ? group_hash_upper[hash_idx[4:0]]
                                : group_hash_lower[hash_idx[4:0]];
  // First received octet sits in the low byte of the lower word
  assign station = {station_addr_upper, station_addr_lower};

  // Registered verdict
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      verdict <= '0;
    end else begin
      verdict.valid <= rx_addr.valid;
      verdict.station_match <= rx_addr.dest == station;
      verdict.group <= rx_addr.dest[0];
      verdict.accept <= rx_addr.dest[0] ? (accept_all_group || hash_bit)
                                        : (rx_addr.dest == station);
    end
  end

  // Management control fields, writable only while idle
  logic ctrl_wr;
  logic start;
  assign ctrl_wr = wr && paddr == PHY_MGMT_CONTROL_OFS && !phy_access_pending;
  assign start = ctrl_wr && next_word[PHY_PENDING_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_addr <= PHY_FIELD_RST;
      phy_reg_index <= PHY_FIELD_RST;
      phy_write_select <= 1'b0;
    end else if (ctrl_wr) begin
      phy_addr <= next_word[PHY_ADDR_MSB:PHY_ADDR_LSB];
      phy_reg_index <= next_word[PHY_INDEX_MSB:PHY_INDEX_LSB];
      phy_write_select <= next_word[PHY_WRITE_BIT];
    end
  end

  // Access sequencer and self-clearing busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= MAHPM_IDLE;
      phy_access_pending <= 1'b0;
      phy_req <= '0;
    end else begin
      unique case (state)
        MAHPM_IDLE: begin
          if (start) begin
            state <= MAHPM_ISSUE;
            phy_access_pending <= 1'b1;
          end
        end
        MAHPM_ISSUE: begin
          phy_req.valid <= 1'b1;
          phy_req.write <= phy_write_select;
          phy_req.phy_addr <= phy_addr;
          phy_req.index <= phy_reg_index;
          phy_req.wdata <= phy_value;
          state <= MAHPM_WAIT;
        end
        MAHPM_WAIT: begin
          if (phy_rsp.done) begin
            phy_req.valid <= 1'b0;
            phy_access_pending <= 1'b0;
            state <= MAHPM_IDLE;
          end
        end
        default: state <= MAHPM_IDLE;
      endcase
    end
  end

  // Data register: software writes while idle, read result loaded at completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_value <= PHY_VALUE_RST;
    end else if (state == MAHPM_WAIT && phy_rsp.done && !phy_req.write) begin
      phy_value <= phy_rsp.rdata;
    end else if (wr && paddr == PHY_MGMT_VALUE_OFS && !phy_access_pending) begin
      phy_value <= next_word[15:0];
    end
  end

  // Checks on the access sequencer and the busy flag
  a_busy_on_start: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> phy_access_pending ##1 phy_req.valid)
    else $error("busy or request missing after start");
  a_busy_held: assert property (@(posedge pclk) disable iff (!presetn)
    phy_req.valid && !phy_rsp.done |=> phy_access_pending)
    else $error("busy dropped during access");
  a_busy_clears: assert property (@(posedge pclk) disable iff (!presetn)
    state == MAHPM_WAIT && phy_rsp.done |=> !phy_access_pending && state == MAHPM_IDLE)
    else $error("busy not cleared at completion");
  // Busy covers the whole walk, so software never sees a gap
  a_busy_state: assert property (@(posedge pclk) disable iff (!presetn)
    phy_access_pending == (state != MAHPM_IDLE))
    else $error("busy flag out of step with sequencer");
  // A stray state code would leave busy stuck
  a_state_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot(state))
    else $error("sequencer state not one-hot");
  // Nothing is offered to the PHY while idle
  a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    state == MAHPM_IDLE |-> !phy_req.valid)
    else $error("request raised while idle");

  // Checks on what the PHY is offered and what comes back
  a_req_steady: assert property (@(posedge pclk) disable iff (!presetn)
    phy_req.valid && !phy_rsp.done |=> $stable(phy_req))
    else $error("request changed before answer");
  // Request copies the registers on the cycle it rises
  a_write_data: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(phy_req.valid) |-> phy_req.wdata == phy_value && phy_req.index == phy_reg_index)
    else $error("request fields wrong");
  a_write_dir: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(phy_req.valid) |-> phy_req.write == phy_write_select)
    else $error("direction wrong");
  a_read_loaded: assert property (@(posedge pclk) disable iff (!presetn)
    state == MAHPM_WAIT && phy_rsp.done && !phy_req.write
      |=> phy_value == $past(phy_rsp.rdata))
    else $error("read data not loaded");
  // A write access leaves the value register as software set it
  a_write_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    state == MAHPM_WAIT && phy_rsp.done && phy_req.write |=> $stable(phy_value))
    else $error("write access disturbed data register");

  // Software writes are shut out while an access runs
  a_value_locked: assert property (@(posedge pclk) disable iff (!presetn)
    phy_access_pending && !phy_rsp.done |=> $stable(phy_value))
    else $error("data register changed during access");
  a_ctrl_locked: assert property (@(posedge pclk) disable iff (!presetn)
    phy_access_pending |=> $stable(phy_reg_index) && $stable(phy_write_select))
    else $error("control fields changed during access");

  // Checks on the receive filter verdict
  // Hash words held still so the verdict traces to one table
  a_hash_accept: assert property (@(posedge pclk) disable iff (!presetn)
    rx_addr.dest[0] && !accept_all_group && $stable(group_hash_upper)
      && $stable(group_hash_lower) |=> verdict.accept == $past(hash_bit))
    else $error("hash verdict wrong");
  a_pass_all: assert property (@(posedge pclk) disable iff (!presetn)
    rx_addr.dest[0] && accept_all_group |=> verdict.accept)
    else $error("pass-all multicast not honoured");
  // Unicast frames are judged by the station address alone
  a_unicast_match: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_addr.dest[0] |=> verdict.accept == verdict.station_match && !verdict.group)
    else $error("unicast verdict wrong");
  a_verdict_valid: assert property (@(posedge pclk) disable iff (!presetn)
    rx_addr.valid |=> verdict.valid && verdict.group == $past(rx_addr.dest[0]))
    else $error("verdict not raised");

  // Checks on register writes; a full-width write lands as sent
  a_lower_write: assert property (
    @(posedge pclk) disable iff (!presetn || !prot_resetn)
    wr && paddr == STATION_ADDR_LOWER_OFS && pstrb == 4'hF
      |=> station_addr_lower == $past(pwdata))
    else $error("lower station word not written");
  a_upper_write: assert property (
    @(posedge pclk) disable iff (!presetn || !prot_resetn)
    wr && paddr == STATION_ADDR_UPPER_OFS && pstrb[1:0] == 2'h3
      |=> station_addr_upper == $past(pwdata[15:0]))
    else $error("upper station word not written");
  a_hash_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == GROUP_HASH_UPPER_OFS && pstrb == 4'hF
      |=> group_hash_upper == $past(pwdata))
    else $error("hash word not written");
  a_value_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == PHY_MGMT_VALUE_OFS && !phy_access_pending && pstrb[1:0] == 2'h3
      |=> phy_value == $past(pwdata[15:0]))
    else $error("data register not written");

  // Checks on the APB answer
  // Reserved control bits read zero
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == PHY_MGMT_CONTROL_OFS |=> prdata[5:2] == 4'h0
      && prdata[31:16] == 16'h0000)
    else $error("reserved bits nonzero");
  a_busy_readback: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == PHY_MGMT_CONTROL_OFS
      |=> prdata[PHY_PENDING_BIT] == $past(phy_access_pending))
    else $error("busy bit misreported");
  // Unmapped offsets answer with an error and zero data
  a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !mapped |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  a_pready_timing: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("pready late");
  // pready stands one cycle, so a back-to-back setup is seen afresh
  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held too long");

  // Main scenarios
  c_phy_read: cover property (@(posedge pclk) disable iff (!presetn)
    state == MAHPM_WAIT && phy_rsp.done && !phy_req.write);
  c_phy_write: cover property (@(posedge pclk) disable iff (!presetn)
    state == MAHPM_WAIT && phy_rsp.done && phy_req.write);
  c_hash_hit: cover property (@(posedge pclk) disable iff (!presetn)
    verdict.valid && verdict.group && verdict.accept);
  c_pass_all: cover property (@(posedge pclk) disable iff (!presetn)
    verdict.valid && verdict.group && verdict.accept && accept_all_group);
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) access && pslverr);
endmodule : mahpm_regs

// ==== dv/mahpm_phy_model.sv ====
// PHY management responder model with an adjustable answer delay
`timescale 1ns/1ps
module mahpm_phy_model
  import mahpm_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Answer delay in cycles
  input wire logic [3:0] lag,
  // Management port
  input wire mahpm_phy_req_t phy_req,
  output mahpm_phy_rsp_t phy_rsp
);
  logic [15:0] mem [32];
  logic [3:0] cnt;
  // Serve one access; read data is scrambled outside the answer cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      phy_rsp <= '0;
    end else begin
      phy_rsp.done <= 1'b0;
      phy_rsp.rdata <= ~phy_rsp.rdata;
      if (phy_req.valid && !phy_rsp.done) begin
        cnt <= cnt + 4'h1;
        if (cnt >= lag) begin
          cnt <= 4'h0;
          phy_rsp.done <= 1'b1;
          // Only the PHY at address one answers with its registers
          if (phy_req.phy_addr != 5'h01) phy_rsp.rdata <= 16'hFFFF;
          else if (phy_req.write) mem[phy_req.index] <= phy_req.wdata;
          else phy_rsp.rdata <= mem[phy_req.index];
        end
      end
    end
  end
endmodule : mahpm_phy_model

// ==== dv/test_mac_addr_hash_phy_mgmt_regs.sv ====
// Self-checking bench for the address, hash and PHY management registers
`timescale 1ns/1ps
module test_mac_addr_hash_phy_mgmt_regs;
  import mahpm_pkg::*;
  logic pclk, presetn, prot_resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, su, sl, hu, hl, w;
  logic [3:0] lag;
  logic [4:0] idx;
  logic [15:0] v;
  logic [47:0] d;
  logic [5:0] h;
  logic e, hb;
  mahpm_rx_addr_t rx_addr;
  mahpm_verdict_t verdict;
  mahpm_phy_req_t phy_req;
  mahpm_phy_rsp_t phy_rsp;
  int errors = 0;
  int n_compared = 0;
  int unsigned seed = 7762;
  logic [11:0] ofs [7] = '{12'h104, 12'h108, 12'h10C, 12'h110, 12'h114, 12'h118, 12'h128};
  logic [31:0] rst [7] = '{32'h0000FFFF, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] msk [4] = '{32'h0000FFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
  mahpm_regs u_dut (.pclk(pclk), .presetn(presetn), .prot_resetn(prot_resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_addr(rx_addr),
    .verdict(verdict), .phy_req(phy_req), .phy_rsp(phy_rsp));
  mahpm_phy_model u_phy (.pclk(pclk), .presetn(presetn), .lag(lag), .phy_req(phy_req),
    .phy_rsp(phy_rsp));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Reference hash: reflected CRC-32 over the address; index is its first six bits reversed
  function automatic logic [5:0] hidx(input logic [47:0] a);
    logic [31:0] c;
    logic fb;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < 48; i++) begin
      fb = c[0] ^ a[i];
      c = c >> 1;
      if (fb) c ^= 32'hEDB88320;
    end
    return {c[0], c[1], c[2], c[3], c[4], c[5]};
  endfunction : hidx
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("mismatch %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask : chk
  task automatic chk_v(input mahpm_verdict_t g, input mahpm_verdict_t x);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("mismatch %0t verdict got %b exp %b", $time, g, x);
    end
  endtask : chk_v
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] t;
    logic te;
    apb(1'b1, a, wd, t, te);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x, "read");
    chk({31'h0, e}, 32'h0, "slverr");
  endtask : rdc
  // Poll busy until clear; it must read set at first
  task automatic wait_idle();
    apb(1'b0, 12'h114, 32'h0, r, e);
    chk({31'h0, r[0]}, 32'h1, "busy");
    while (r[0] !== 1'b0) begin
      apb(1'b0, 12'h114, 32'h0, r, e);
    end
  endtask : wait_idle
  task automatic give_verdict();
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // Watchdog
  initial begin
    repeat (30000) @(posedge pclk);
    errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {presetn, prot_resetn, psel, penable, pwrite, paddr, pwdata, lag} = '0;
    rx_addr = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    prot_resetn <= 1'b1;
    @(posedge pclk);
    foreach (ofs[i]) rdc(ofs[i], rst[i]);
    apb(1'b0, 12'h200, 32'h0, r, e);
    chk({r[31:1], e}, 32'h1, "unmapped");
    for (int i = 0; i < 4; i++) begin
      w = rnd();
      wr(ofs[i], w);
      rdc(ofs[i], w & msk[i]);
    end
    su = rnd() & 32'h0000FFFF;
    sl = rnd() & 32'hFFFFFFFE;
    wr(12'h104, su);
    wr(12'h108, sl);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(12'h104, su);
    rdc(12'h108, sl);
    rdc(12'h10C, 32'h0);
    rdc(12'h110, 32'h0);
    rdc(12'h114, 32'h0);
    for (int k = 0; k < 4; k++) begin
      lag <= 4'(k * 5);
      idx = 5'(rnd());
      v = 16'(rnd());
      wr(12'h118, {16'hFFFF, v});
      wr(12'h114, {16'h0, 5'h01, idx, 4'h0, 2'b11});
      wait_idle();
      wr(12'h118, 32'h0);
      wr(12'h114, {16'h0, 5'h01, idx, 4'h0, 2'b01});
      wait_idle();
      rdc(12'h118, {16'h0, v});
      rdc(12'h114, {16'h0, 5'h01, idx, 6'h0});
    end
    hu = rnd();
    hl = rnd();
    wr(12'h10C, hu);
    wr(12'h110, hl);
    for (int m = 0; m < 2; m++) begin
      wr(12'h128, 32'(m));
      for (int j = 0; j < 32; j++) begin
        d = {16'(rnd()), rnd()};
        if (j % 4 == 0) d = {su[15:0], sl};
        h = hidx(d);
        hb = h[5] ? hu[h[4:0]] : hl[h[4:0]];
        @(posedge pclk);
        rx_addr <= {1'b1, d};
        @(posedge pclk);
        #1;
        chk_v(verdict, {1'b1, d == {su[15:0], sl}, d[0],
                        d[0] ? (m[0] | hb) : (d == {su[15:0], sl})});
      end
    end
    rx_addr <= '0;
    @(posedge pclk);
    give_verdict();
  end
endmodule : test_mac_addr_hash_phy_mgmt_regs
